// [hw/nv_array.v]
// Byte-wide storage array with one write and one read port
`timescale 1ns/1ps
`include "nv_access_regs.vh"

module nv_array (
    // Clock
    input  wire                      ref_clk_in,
    // Write port
    input  wire                      wr_en_in,
    input  wire [`NV_ADDR_W-1:0]     wr_addr_in,
    input  wire [7:0]                wr_data_in,
    // Read port, combinational
    input  wire [`NV_ADDR_W-1:0]     rd_addr_in,
    output wire [7:0]                rd_data_out
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // No reset: contents are nonvolatile in spirit, undefined at start
    reg [7:0] mem_r [0:`NV_DEPTH-1];

    // Byte is committed in one clock, far shorter than a bus bit
    always @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_data_out = mem_r[rd_addr_in];

endmodule

// [hw/pin_sync.v]
// Two-flop synchroniser with edge detection for the bus pins
`timescale 1ns/1ps
`include "nv_access_regs.vh"

module pin_sync (
    // Clock and reset
    input  wire ref_clk_in,
    input  wire rstn_in,
    // Asynchronous pin level
    input  wire pin_in,
    // Synchronised level and edges
    output wire level_out,
    output wire rise_out,
    output wire fall_out
);

    // ----------------------------------------------------------------
    // Synchroniser chain
    // ----------------------------------------------------------------
    reg meta_r;   // First stage, read only by sync_r
    reg sync_r;   // Second stage, safe level
    reg prev_r;   // Delayed copy for edge finding

    // Idle bus floats high, so reset to high to avoid a false edge
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_out = sync_r;
    assign rise_out  = sync_r & ~prev_r;
    assign fall_out  = ~sync_r & prev_r;

endmodule

// [hw/two_wire_nv_memory_access.v]
// Two-wire slave access logic for an 8192-byte nonvolatile memory
`timescale 1ns/1ps
`include "nv_access_regs.vh"

// Summary of operation
// - Two address bytes, upper first, 13 bits
// - Address latch increments on each unprotected data byte
// - Latch holds until new address written
// - Reads start from current latch value
// - Increment after byte, before acknowledge slot
// - Latch wraps from last location to zero
// - No limit on bytes per transfer
// - Read: send byte, release, act on ack
// - Write: take byte, then drive ack
// - All bytes most significant bit first
// - No busy time, no page buffer
// - Commit after eighth bit; earlier abort discards
// - Write protect: no ack, no increment
// - Read select shifts data on next clock
// - Selective read: address write, restart, read
// - Select byte type and chip select match, rw picks direction
// - Start aborts anything, awaits select byte
// - Sample on rise, change on fall
module two_wire_nv_memory_access (
    // Clock and reset
    input  wire       ref_clk_in,
    input  wire       rstn_in,
    // Two-wire bus
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe_out,
    // Straps
    input  wire [2:0] chip_select_pins_in,
    input  wire       write_protect_in
);

    // ----------------------------------------------------------------
    // Byte phases
    // ----------------------------------------------------------------
    localparam ST_IDLE   = 3'h0; // Not addressed, wait for start
    localparam ST_SEL    = 3'h1; // Receiving select byte
    localparam ST_ADDRHI = 3'h2; // Receiving upper address byte
    localparam ST_ADDRLO = 3'h3; // Receiving lower address byte
    localparam ST_WDATA  = 3'h4; // Receiving data bytes
    localparam ST_RDATA  = 3'h5; // Sending data bytes

    // ----------------------------------------------------------------
    // Address increment with wrap, shared by read and write paths
    // ----------------------------------------------------------------
    function [`NV_ADDR_W-1:0] addr_inc;
        input [`NV_ADDR_W-1:0] a;
        begin
            if (a == `NV_ADDR_LAST) begin
                addr_inc = `NV_ADDR_ZERO;
            end else begin
                addr_inc = a + `NV_ADDR_ONE;
            end
        end
    endfunction

    // Eighth data bit of a byte is being sampled on this clock rise
    function byte_end;
        input                  rise;
        input [`BIT_CNT_W-1:0] cnt;
        begin
            byte_end = rise && (cnt == `BIT_CNT_LAST);
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    wire scl_lvl;   // Synchronised clock level
    wire scl_rise;  // Clock rising edge
    wire scl_fall;  // Clock falling edge
    wire sda_lvl;   // Synchronised data level
    wire sda_rise;  // Data rising edge
    wire sda_fall;  // Data falling edge
    reg  [1:0] wp_sync_r;  // Write protect synchroniser
    reg  [1:0] cs0_sync_r; // Chip select synchronisers
    reg  [1:0] cs1_sync_r;
    reg  [1:0] cs2_sync_r;

    // Clock line: its edges pace the bit engine
    pin_sync u_scl_sync (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .pin_in     (scl_in),
        .level_out  (scl_lvl),
        .rise_out   (scl_rise),
        .fall_out   (scl_fall)
    );

    // Data line: its edges only matter while the clock is high
    pin_sync u_sda_sync (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .pin_in     (sda_in),
        .level_out  (sda_lvl),
        .rise_out   (sda_rise),
        .fall_out   (sda_fall)
    );

    // Static pins get two stages too; they may change at any time
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wp_sync_r  <= 2'h0;
            cs0_sync_r <= 2'h0;
            cs1_sync_r <= 2'h0;
            cs2_sync_r <= 2'h0;
        end else begin
            wp_sync_r  <= {wp_sync_r[0], write_protect_in};
            cs0_sync_r <= {cs0_sync_r[0], chip_select_pins_in[0]};
            cs1_sync_r <= {cs1_sync_r[0], chip_select_pins_in[1]};
            cs2_sync_r <= {cs2_sync_r[0], chip_select_pins_in[2]};
        end
    end

    wire       wp_lvl = wp_sync_r[1];                                    // Protect, safe level
    wire [2:0] cs_lvl = {cs2_sync_r[1], cs1_sync_r[1], cs0_sync_r[1]}; // Straps, safe level

    // ----------------------------------------------------------------
    // Bus conditions
    // ----------------------------------------------------------------
    // Both lines pass the same synchroniser depth, so their relative
    // order is kept; a data edge while the clock is high is a condition
    wire start_det = sda_fall & scl_lvl;
    wire stop_det  = sda_rise & scl_lvl;

    // ----------------------------------------------------------------
    // Protocol state
    // ----------------------------------------------------------------
    reg  [2:0]            state_r;    // Current byte phase
    reg  [`BIT_CNT_W-1:0] bit_cnt_r;  // Bits done in current byte; 8 = ack slot
    reg  [7:0]            shift_r;    // Receive or transmit shift register
    reg  [`NV_ADDR_W-1:0] addr_r;     // Current address latch
    reg  [4:0]            addr_hi_r;  // Upper address bits awaiting low byte
    reg                   ack_ok_r;   // We acknowledge the current byte
    reg                   mst_ack_r;  // Master acknowledged our byte
    reg                   wr_en_r;    // One-clock array write strobe
    reg  [7:0]            wr_data_r;  // Byte to commit
    reg  [`NV_ADDR_W-1:0] wr_addr_r;  // Where to commit
    wire [7:0]            rd_data;    // Array byte at latch

    wire [7:0] rx_byte = {shift_r[6:0], sda_lvl};
    wire sel_match = (rx_byte[`SEL_TYPE_HI:`SEL_TYPE_LO] == `SEL_TYPE_CODE) &&
                     (rx_byte[`SEL_CS_HI:`SEL_CS_LO] == cs_lvl);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Array writes take one clock, so a byte is stored long before its ack
    nv_array u_array (
        .ref_clk_in  (ref_clk_in),
        .wr_en_in    (wr_en_r),
        .wr_addr_in  (wr_addr_r),
        .wr_data_in  (wr_data_r),
        .rd_addr_in  (addr_r),
        .rd_data_out (rd_data)
    );

    // ----------------------------------------------------------------
    // Address latch
    // ----------------------------------------------------------------
    // The latch has no reset value on purpose, mirroring power-up
    // A master that needs a known start must load it first with a
    // selective read; reading straight after power-up gives junk
    always @(posedge ref_clk_in) begin
        if (state_r == ST_ADDRLO && byte_end(scl_rise, bit_cnt_r)) begin
            // Low byte completes the address; load both halves at once
            addr_r <= {addr_hi_r, rx_byte};
        end else if (byte_end(scl_rise, bit_cnt_r) &&
                     ((state_r == ST_WDATA && !wp_lvl) || state_r == ST_RDATA)) begin
            // Step at the eighth bit, ahead of the ack slot, so the next
            // read byte already stands on the array's read port
            addr_r <= addr_inc(addr_r);
        end
        // Otherwise the latch holds, across stops and starts
    end

    // ----------------------------------------------------------------
    // Bit engine: sample on clock rise, drive on clock fall
    // ----------------------------------------------------------------
    // Outputs move two to three clocks after the bus clock falls, the
    // synchroniser depth; that stays well inside the low phase of the
    // bus clock, so setup at the master's next rise is kept.
    // Start and stop win over bit handling in the same clock, since a
    // condition means the byte in flight is no longer valid.
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r    <= ST_IDLE;
            bit_cnt_r  <= `BIT_CNT_ZERO;
            shift_r    <= 8'h00;
            addr_hi_r  <= 5'h00;
            ack_ok_r   <= 1'b0;
            mst_ack_r  <= 1'b0;
            wr_en_r    <= 1'b0;
            wr_data_r  <= 8'h00;
            wr_addr_r  <= `NV_ADDR_ZERO;
            sda_out    <= 1'b1;
            sda_oe_out <= 1'b0;
        end else begin
            wr_en_r <= 1'b0;
            if (start_det) begin
                // Abort whatever runs; partial bytes are dropped
                state_r    <= ST_SEL;
                bit_cnt_r  <= `BIT_CNT_ZERO;
                sda_oe_out <= 1'b0;
            end else if (stop_det) begin
                state_r    <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end else if (state_r != ST_IDLE && scl_rise) begin
                if (bit_cnt_r == `BIT_CNT_ACK) begin
                    // Ack slot: master's ack decides whether reading goes on
                    mst_ack_r <= ~sda_lvl;
                    bit_cnt_r <= `BIT_CNT_ZERO;
                    // A read goes on or ends at the next fall, by the master's
                    // ack; any other byte we did not ack ends our part here
                    if (!ack_ok_r && state_r != ST_RDATA) begin
                        state_r <= ST_IDLE; // Protected data byte
                    end
                end else begin
                    // While sending, the register holds outgoing bits and
                    // must not take in the wire's echo of them
                    if (state_r != ST_RDATA) begin
                        shift_r <= rx_byte;
                    end
                    bit_cnt_r <= bit_cnt_r + `BIT_CNT_ONE;
                    if (byte_end(scl_rise, bit_cnt_r)) begin
                        case (state_r)
                            ST_SEL: begin
                                // Another device's select: go quiet until next start
                                ack_ok_r <= sel_match;
                                if (!sel_match) begin
                                    state_r <= ST_IDLE;
                                end else if (rx_byte[`SEL_RW_BIT]) begin
                                    state_r <= ST_RDATA;
                                end else begin
                                    state_r <= ST_ADDRHI;
                                end
                            end
                            ST_ADDRHI: begin
                                // Address bytes are acked even under protection
                                addr_hi_r <= rx_byte[4:0]; // Top three bits ignored
                                ack_ok_r  <= 1'b1;
                                state_r   <= ST_ADDRLO;
                            end
                            ST_ADDRLO: begin
                                // The latch itself loads in the latch process
                                ack_ok_r <= 1'b1;
                                state_r  <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                // Commit right after the 8th bit, no buffering
                                wr_en_r   <= ~wp_lvl;
                                wr_data_r <= rx_byte;
                                wr_addr_r <= addr_r;
                                ack_ok_r  <= ~wp_lvl;
                            end
                            default: begin
                                ack_ok_r <= 1'b0; // Read byte: master acks
                            end
                        endcase
                    end
                end
            end else if (state_r != ST_IDLE && scl_fall) begin
                // Output changes only on the falling clock
                if (bit_cnt_r == `BIT_CNT_ACK) begin
                    if (ack_ok_r) begin
                        sda_out    <= 1'b0;
                        sda_oe_out <= 1'b1;
                    end else begin
                        sda_oe_out <= 1'b0; // Release for master ack
                    end
                end else if (state_r == ST_RDATA && bit_cnt_r == `BIT_CNT_ZERO) begin
                    // Byte boundary: ack_ok_r marks the select ack just given,
                    // mst_ack_r the master's ack of the byte just sent
                    if (ack_ok_r || mst_ack_r) begin
                        // First byte after select ack, or acked byte
                        sda_out    <= rd_data[7];
                        shift_r    <= {rd_data[6:0], 1'b0};
                        sda_oe_out <= 1'b1;
                        ack_ok_r   <= 1'b0;
                        mst_ack_r  <= 1'b0;
                    end else begin
                        state_r    <= ST_IDLE; // Nack ends the read
                        sda_oe_out <= 1'b0;
                    end
                end else if (state_r == ST_RDATA) begin
                    sda_out    <= shift_r[7];
                    shift_r    <= {shift_r[6:0], 1'b0};
                    sda_oe_out <= 1'b1;
                end else begin
                    sda_oe_out <= 1'b0;
                end
            end
        end
    end

endmodule

// [include/nv_access_regs.vh]
// Constants for the two-wire nonvolatile memory access block
`ifndef NV_ACCESS_REGS_VH
`define NV_ACCESS_REGS_VH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define NV_ADDR_W        13
`define NV_DEPTH         8192
`define NV_ADDR_LAST     13'h1FFF
`define NV_ADDR_ZERO     13'h0000
`define NV_ADDR_ONE      13'h0001

// ----------------------------------------------------------------
// Select byte layout
// ----------------------------------------------------------------
`define SEL_TYPE_HI      7
`define SEL_TYPE_LO      4
`define SEL_CS_HI        3
`define SEL_CS_LO        1
`define SEL_RW_BIT       0
// Device type code; value is arbitrary, override per part
`define SEL_TYPE_CODE    4'h5

// ----------------------------------------------------------------
// Bit counting
// ----------------------------------------------------------------
`define BIT_CNT_W        4
`define BIT_CNT_ZERO     4'h0
`define BIT_CNT_ONE      4'h1
`define BIT_CNT_LAST     4'h7
`define BIT_CNT_ACK      4'h8

`endif

// [verif/two_wire_chk.sv]
// Checker for the two-wire memory access block
`timescale 1ns/1ps
`include "nv_access_regs.vh"
module two_wire_chk (
    // Clock and reset
    input wire       ref_clk_in,
    input wire       rstn_in,
    // Bus and straps
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe_out,
    input wire [2:0] chip_select_pins_in,
    input wire       write_protect_in
);
    // ----------
    // Bus monitor
    // ----------
    reg        scl_r;   // Clock one cycle ago
    reg        sda_r;   // Data one cycle ago
    reg        rd_r;    // Select asked for a read
    reg        ok_r;    // Select matched this device
    reg  [3:0] bit_r;   // Rises since start or ack
    reg  [3:0] fall_r;  // Cycles since clock fell
    reg  [1:0] idx_r;   // Byte index, saturating
    reg  [6:0] sh_r;    // Bits shifted in
    wire [7:0] byte_w = {sh_r, sda_in};
    wire       rise   = !scl_r && scl_in;
    wire       start  = scl_r && scl_in && sda_r && !sda_in;
    wire       stop   = scl_r && scl_in && !sda_r && sda_in;
    wire       eighth = rise && bit_r == 4'h7;
    wire       match  = byte_w[7:4] == `SEL_TYPE_CODE && byte_w[3:1] == chip_select_pins_in;
    wire       ev_sel = eighth && idx_r == 2'h0;
    wire       ev_wd  = eighth && idx_r == 2'h3 && ok_r && !rd_r;
    wire       ev_rak = rise && bit_r == 4'h8 && idx_r != 2'h0 && ok_r && rd_r;
    // Bench pins are clean, so raw sampling is enough here
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {scl_r, sda_r, rd_r, ok_r} <= 4'hC;
            bit_r  <= 4'h0;
            fall_r <= 4'hF;
            idx_r  <= 2'h0;
            sh_r   <= 7'h00;
        end else begin
            scl_r  <= scl_in;
            sda_r  <= sda_in;
            fall_r <= (scl_r && !scl_in) ? 4'h0 : (fall_r == 4'hF) ? fall_r : fall_r + 4'h1;
            if (start) begin
                bit_r <= 4'h0;
                idx_r <= 2'h0;
            end else if (rise) begin
                sh_r  <= byte_w[6:0];
                bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
                if (bit_r == 4'h8 && idx_r != 2'h3) idx_r <= idx_r + 2'h1;
                if (ev_sel) begin
                    rd_r <= byte_w[0];
                    ok_r <= match;
                end
            end
        end
    end
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence quiet8_s; !sda_oe_out [*8]; endsequence
    sequence ack_s; ##[1:10] (sda_oe_out && !sda_out); endsequence
    a_sel_ack: assert property (ev_sel && match |-> ack_s) else $error("select not acknowledged");
    a_sel_quiet: assert property (ev_sel && !match |-> quiet8_s ##1 quiet8_s) else $error("foreign select driven");
    a_wr_ack: assert property (ev_wd && !write_protect_in |-> ack_s) else $error("data byte not acknowledged");
    a_wp_nack: assert property (ev_wd && write_protect_in |-> quiet8_s ##1 quiet8_s) else $error("protected byte acked");
    a_rd_release: assert property (ev_rak |-> !sda_oe_out) else $error("line held in master ack slot");
    a_stop_idle: assert property (stop |-> quiet8_s) else $error("line driven after stop");
    a_oe_stands: assert property ($rose(sda_oe_out) |-> sda_oe_out [*6]) else $error("drive dropped early");
    a_change_fall: assert property (($changed(sda_oe_out) || (sda_oe_out && $changed(sda_out)))
        |-> fall_r <= 4'h5) else $error("output changed away from clock fall");
endmodule
bind two_wire_nv_memory_access two_wire_chk u_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .chip_select_pins_in(chip_select_pins_in),
    .write_protect_in(write_protect_in));

// [verif/two_wire_master.sv]
// Two-wire bus master model that makes the serial clock
`timescale 1ns/1ps
module two_wire_master (
    // Clock
    input  wire ref_clk_in,
    // Bus, open drain: a one releases the line
    input  wire sda_in,
    output reg  scl_out,
    output reg  sda_drv_out
);
    // Idle bus: clock stands high, data released
    initial begin
        scl_out     = 1'b1;
        sda_drv_out = 1'b1;
    end
    task tick(input integer n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    // One 32 ns clock: data moves in the low phase, sampled while high
    task bit_cyc(input b, output s);
        tick(3);
        sda_drv_out <= b;
        tick(3);
        scl_out <= 1'b1;
        tick(1);
        s = sda_in;
        tick(1);
        scl_out <= 1'b0;
    endtask
    // Long low phase first so a slave ack is gone before the clock rises
    task start_c;
        tick(1);
        sda_drv_out <= 1'b1;
        tick(5);
        scl_out <= 1'b1;
        tick(3);
        sda_drv_out <= 1'b0;
        tick(3);
        scl_out <= 1'b0;
    endtask
    task stop_c;
        tick(2);
        sda_drv_out <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        sda_drv_out <= 1'b1;
        tick(4);
    endtask
    // Sends n bits, most significant first
    task wr_bits(input [7:0] d, input integer n);
        integer i;
        reg     s;
        for (i = 7; i > 7 - n; i = i - 1) bit_cyc(d[i], s);
    endtask
    task wr_byte(input [7:0] d, output a);
        wr_bits(d, 8);
        bit_cyc(1'b1, a);
    endtask
    task rd_raw(output [7:0] d);
        integer i;
        reg     s;
        for (i = 0; i < 8; i = i + 1) begin
            bit_cyc(1'b1, s);
            d = {d[6:0], s};
        end
    endtask
    // A one in the ack slot ends the read
    task rd_byte(input nak, output [7:0] d);
        reg s;
        rd_raw(d);
        bit_cyc(nak, s);
    endtask
endmodule

// [verif/two_wire_nv_memory_access_tb.sv]
// Testbench for the two-wire memory access block
`timescale 1ns/1ps
`include "nv_access_regs.vh"
module two_wire_nv_memory_access_tb;
    localparam [2:0] cs_val = 3'h5;  // Strap value of this device
    reg        ref_clk_in = 1'b0;
    reg        rstn_in    = 1'b0;
    reg        wp_r       = 1'b0;
    reg  [2:0] cs_r       = cs_val;  // Strap pins, moved by one scenario
    wire       scl;
    wire       sda_drv;
    wire       sda_out;
    wire       sda_oe;
    wire       sda_wire = (sda_oe ? sda_out : 1'b1) & sda_drv;  // Pulled-up wire
    integer    num_errors  = 0;
    integer    check_count = 0;
    integer    cyc         = 0;
    integer    i;
    reg        a_r;
    reg  [7:0] d_r;
    always #2 ref_clk_in = ~ref_clk_in;
    two_wire_nv_memory_access dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .chip_select_pins_in(cs_r), .write_protect_in(wp_r));
    two_wire_master m (.ref_clk_in(ref_clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_drv_out(sda_drv));
    task test_done;
        if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Whole run is a few thousand cycles; a hang stops here
    always @(posedge ref_clk_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    task chk(input [7:0] exp, input [7:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // Acknowledge bit as seen on the wire: zero means acknowledged
    task chk_ack(input exp, input got);
        check_count = check_count + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    function [7:0] sel(input rw);
        sel = {`SEL_TYPE_CODE, cs_val, rw};
    endfunction
    function [7:0] pat(input integer k);
        pat = 8'hA1 + 8'h11 * k[7:0];
    endfunction
    // Write select plus both address bytes; ack reads as zero
    task set_addr(input [15:0] a);
        m.start_c;
        m.wr_byte(sel(1'b0), a_r);
        chk_ack(1'b0, a_r);
        m.wr_byte(a[15:8], a_r);
        chk_ack(1'b0, a_r);
        m.wr_byte(a[7:0], a_r);
        chk_ack(1'b0, a_r);
    endtask
    // Four bytes from 1FFE, upper address bits set, across the wrap
    task t_write_wrap;
        set_addr(16'hFFFE);
        for (i = 0; i < 4; i = i + 1) begin
            m.wr_byte(pat(i), a_r);
            chk_ack(1'b0, a_r);
        end
        m.stop_c;
    endtask
    // Selective read straight after a write, then current read
    task t_sel_read;
        set_addr(16'h1FFE);
        m.start_c;
        m.wr_byte(sel(1'b1), a_r);
        chk_ack(1'b0, a_r);
        for (i = 0; i < 3; i = i + 1) begin
            m.rd_byte(i == 2, d_r);
            chk(pat(i), d_r);
        end
        m.start_c;
        m.wr_byte(sel(1'b1), a_r);
        m.rd_byte(1'b1, d_r);
        chk(pat(3), d_r);
        m.stop_c;
    endtask
    // Wrong type code, wrong chip select bits, then moved strap pins
    task t_bad_sel;
        for (i = 0; i < 3; i = i + 1) begin
            if (i == 2) cs_r <= cs_val ^ 3'h6;
            m.start_c;
            m.wr_byte(sel(1'b0) ^ (i == 0 ? 8'h80 : i == 1 ? 8'h02 : 8'h00), a_r);
            chk_ack(1'b1, a_r);
            m.stop_c;
        end
        cs_r <= cs_val;
    endtask
    // Protected write leaves both data and latch alone
    task t_wp;
        @(posedge ref_clk_in) wp_r <= 1'b1;
        set_addr(16'h0001);
        m.wr_byte(8'h55, a_r);
        chk_ack(1'b1, a_r);
        m.stop_c;
        wp_r <= 1'b0;
        m.start_c;
        m.wr_byte(sel(1'b1), a_r);
        m.rd_byte(1'b1, d_r);
        chk(pat(3), d_r);
        m.stop_c;
    endtask
    // Start after five data bits drops the byte; read ends with stop in 9th clock
    task t_abort;
        set_addr(16'h2000);
        m.wr_bits(8'h00, 5);
        m.start_c;
        m.wr_byte(sel(1'b1), a_r);
        m.rd_raw(d_r);
        chk(pat(2), d_r);
        m.stop_c;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        t_write_wrap;
        t_sel_read;
        t_bad_sel;
        t_wp;
        t_abort;
        test_done;
    end
endmodule
